// file: wake_defines.svh
// constants for the wake input monitor: offsets, fields, resets, timing
`ifndef WAKE_DEFINES_SVH
`define WAKE_DEFINES_SVH

// register byte offsets
`define OFF_DETECT_CFG 8'h00
`define OFF_PULL_CFG 8'h04
`define OFF_WAKE_EN 8'h08
`define OFF_WAKE_STAT 8'h0C
`define OFF_ALT_STAT 8'h10
`define OFF_LEVEL_STAT 8'h14
`define OFF_IRQ_MASK 8'h18

// field positions
`define SEL_W 2
`define FO_EN_LSB 3
`define ALT_MASK_LSB 3

// reset values
`define DETECT_CFG_RST 6'h00
`define PULL_CFG_RST 6'h00
`define WAKE_EN_RST 5'h00
`define IRQ_MASK_RST 5'h00

// bus response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// filter timing
`define CLK_PERIOD_NS 40
`define FILT_SHORT_US 16
`define FILT_LONG_US 64
`define FILT_SHORT_CYC ((`FILT_SHORT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILT_LONG_CYC ((`FILT_LONG_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: wake_pkg.sv
// types shared by the wake input monitor
package wake_pkg;

    typedef enum logic [3:0] {
        MODE_NORMAL = 4'h1,
        MODE_STOP = 4'h2,
        MODE_SLEEP = 4'h4,
        MODE_FAIL_SAFE = 4'h8
    } chip_mode_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'h1,
        WR_RESP = 2'h2
    } wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h1,
        RD_DATA = 2'h2
    } rd_state_t;

    typedef struct packed {
        logic up;
        logic down;
    } pull_ctrl_t;

    typedef struct packed {
        logic [1:0] detect_sel;
        logic [1:0] pull_sel;
    } input_cfg_t;

endpackage : wake_pkg

// file: wake_filter.sv
// edge filter for one wake input
`timescale 1ns/1ps
`include "wake_defines.svh"

module wake_filter #(
    parameter int SHORT_CYC = `FILT_SHORT_CYC,
    parameter int LONG_CYC = `FILT_LONG_CYC,
    parameter int CNT_W = 11
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic active,
    input wire logic long_sel,
    input wire logic pin_in,
    // result
    output logic level,
    output logic event_pulse
);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] limit;
    logic level_q;
    logic primed_q;
    logic event_q;
    logic done;

    assign limit = long_sel ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1);
    // recognised only if the pin stays across the threshold for the whole time
    assign done = active && primed_q && (pin_in != level_q) && (cnt_q == limit);

    // a return across the threshold restarts the interval
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
        end else if (!active || pin_in == level_q || done) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    // first active sample loads the level without an event
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            primed_q <= 1'b0;
        end else if (active) begin
            primed_q <= 1'b1;
        end
    end

    // both directions of a change count as an event
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_q <= 1'b0;
        end else if (active && (!primed_q || done)) begin
            level_q <= pin_in;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_q <= 1'b0;
        end else begin
            event_q <= done;
        end
    end

    assign level = level_q;
    assign event_pulse = event_q;

endmodule : wake_filter

// file: wake_input_monitor.sv
// wake input monitor: three wake inputs, two fail-out wake inputs, axi4-lite registers
// Contract
// - three independent wake inputs, each fully equipped
// - rising and falling crossings both signal
// - interrupt in normal/stop, wake-up in sleep/fail-safe
// - static sense detects continuously
// - cyclic sense detects only in timer window
// - filter restarts on crossing, recognise if stable
// - detect 00 static short, 01 static long
// - detect 10 timer a, 11 timer b
// - pull 00 none, 01 down, 10 up, 11 auto
// - auto pull follows detected input level
// - per-pin enable gates wake source
// - per-pin sticky wake status, always readable
// - level status in normal and stop
// - cyclic sense level holds last window sample
// - fail-out wake inputs: static short, separate status
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "wake_defines.svh"

module wake_input_monitor #(
    parameter int N_WAKE = 3,
    parameter int N_FO = 2,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // mode controller and cyclic timers
    input wire wake_pkg::chip_mode_t chip_mode,
    input wire logic timer_a_on,
    input wire logic timer_b_on,
    // pins
    input wire logic [N_WAKE-1:0] wake_pin,
    input wire logic [N_FO-1:0] fail_out_pins,
    // outputs
    output wake_pkg::pull_ctrl_t [N_WAKE-1:0] wake_pull,
    output logic irq,
    output logic wake_req
);

    import wake_pkg::*;

    // configuration and status registers
    logic [2*N_WAKE-1:0] detect_cfg_q;
    logic [2*N_WAKE-1:0] pull_cfg_q;
    logic [N_WAKE+N_FO-1:0] wake_en_q;
    logic [N_WAKE+N_FO-1:0] irq_mask_q;
    logic [N_WAKE-1:0] wake_stat_q;
    logic [N_FO-1:0] alt_stat_q;
    logic [N_WAKE-1:0] level_stat_q;

    // bus interface state
    wr_state_t wr_state_q;
    rd_state_t rd_state_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    // register decode
    logic wr_fire;
    logic wr_byte0;
    logic wr_known;
    logic wr_detect;
    logic wr_pull;
    logic wr_en;
    logic wr_stat;
    logic wr_alt;
    logic wr_mask;
    logic rd_fire;
    logic rd_known;
    logic [31:0] rd_word;
    logic [N_WAKE-1:0] stat_clr;
    logic [N_FO-1:0] alt_clr;

    // per-input detection
    logic [N_WAKE-1:0] wk_active;
    logic [N_WAKE-1:0] wk_long;
    logic [N_WAKE-1:0] wk_level;
    logic [N_WAKE-1:0] wk_event;
    logic [N_FO-1:0] fo_event;
    pull_ctrl_t [N_WAKE-1:0] pull_d;
    pull_ctrl_t [N_WAKE-1:0] wake_pull_q;

    // interrupt and wake request
    logic normal_or_stop;
    logic sleep_or_fail_safe;
    logic pending;
    logic irq_q;
    logic wake_req_q;

    assign wr_fire = awvalid && awready_q && wvalid && wready_q;
    assign wr_byte0 = wr_fire && wstrb[0];
    assign wr_detect = wr_byte0 && (awaddr == ADDR_W'(`OFF_DETECT_CFG));
    assign wr_pull = wr_byte0 && (awaddr == ADDR_W'(`OFF_PULL_CFG));
    assign wr_en = wr_byte0 && (awaddr == ADDR_W'(`OFF_WAKE_EN));
    assign wr_stat = wr_byte0 && (awaddr == ADDR_W'(`OFF_WAKE_STAT));
    assign wr_alt = wr_byte0 && (awaddr == ADDR_W'(`OFF_ALT_STAT));
    assign wr_mask = wr_byte0 && (awaddr == ADDR_W'(`OFF_IRQ_MASK));
    assign wr_known = (awaddr == ADDR_W'(`OFF_DETECT_CFG)) || (awaddr == ADDR_W'(`OFF_PULL_CFG))
        || (awaddr == ADDR_W'(`OFF_WAKE_EN)) || (awaddr == ADDR_W'(`OFF_WAKE_STAT))
        || (awaddr == ADDR_W'(`OFF_ALT_STAT)) || (awaddr == ADDR_W'(`OFF_LEVEL_STAT))
        || (awaddr == ADDR_W'(`OFF_IRQ_MASK));
    assign stat_clr = wr_stat ? wdata[N_WAKE-1:0] : '0;
    assign alt_clr = wr_alt ? wdata[N_FO-1:0] : '0;
    assign rd_fire = arvalid && arready_q;

    // static sense always on, cyclic sense only in its timer window
    generate
        for (genvar i = 0; i < N_WAKE; i++) begin : g_wake
            logic [1:0] det;
            logic [1:0] pul;
            assign det = detect_cfg_q[2*i +: 2];
            assign pul = pull_cfg_q[2*i +: 2];
            assign wk_active[i] = det[1] ? (det[0] ? timer_b_on : timer_a_on)
                : 1'b1;
            assign wk_long[i] = (det == 2'h1);
            // automatic switching follows the filtered level
            assign pull_d[i] = (pul == 2'h3) ? {wk_level[i], !wk_level[i]} : pul;

            wake_filter #(
                .SHORT_CYC(`FILT_SHORT_CYC),
                .LONG_CYC(`FILT_LONG_CYC),
                .CNT_W(11)
            ) u_filt (
                .aclk(aclk),
                .aresetn(aresetn),
                .active(wk_active[i]),
                .long_sel(wk_long[i]),
                .pin_in(wake_pin[i]),
                .level(wk_level[i]),
                .event_pulse(wk_event[i])
            );
        end

        // repurposed fail-out pins: static sense, short filter
        for (genvar j = 0; j < N_FO; j++) begin : g_fail_out
            wake_filter #(
                .SHORT_CYC(`FILT_SHORT_CYC),
                .LONG_CYC(`FILT_LONG_CYC),
                .CNT_W(11)
            ) u_filt (
                .aclk(aclk),
                .aresetn(aresetn),
                .active(wake_en_q[N_WAKE+j]),
                .long_sel(1'b0),
                .pin_in(fail_out_pins[j]),
                .level(),
                .event_pulse(fo_event[j])
            );
        end
    endgenerate

    // configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            detect_cfg_q <= (2*N_WAKE)'(`DETECT_CFG_RST);
        end else if (wr_detect) begin
            detect_cfg_q <= wdata[2*N_WAKE-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pull_cfg_q <= (2*N_WAKE)'(`PULL_CFG_RST);
        end else if (wr_pull) begin
            pull_cfg_q <= wdata[2*N_WAKE-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_en_q <= (N_WAKE+N_FO)'(`WAKE_EN_RST);
        end else if (wr_en) begin
            wake_en_q <= wdata[N_WAKE+N_FO-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_q <= (N_WAKE+N_FO)'(`IRQ_MASK_RST);
        end else if (wr_mask) begin
            irq_mask_q <= wdata[N_WAKE+N_FO-1:0];
        end
    end

    // a new event outranks a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_stat_q <= '0;
        end else begin
            wake_stat_q <= (wake_stat_q & ~stat_clr) | (wk_event & wake_en_q[N_WAKE-1:0]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alt_stat_q <= '0;
        end else begin
            alt_stat_q <= (alt_stat_q & ~alt_clr) | (fo_event & wake_en_q[N_WAKE +: N_FO]);
        end
    end

    // filter level only moves while detection is active
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_stat_q <= '0;
        end else if (normal_or_stop) begin
            level_stat_q <= wk_level;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_pull_q <= '0;
        end else begin
            wake_pull_q <= pull_d;
        end
    end

    assign normal_or_stop = (chip_mode == MODE_NORMAL) || (chip_mode == MODE_STOP);
    assign sleep_or_fail_safe = (chip_mode == MODE_SLEEP) || (chip_mode == MODE_FAIL_SAFE);
    assign pending = |({alt_stat_q, wake_stat_q} & ~irq_mask_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
            wake_req_q <= 1'b0;
        end else begin
            irq_q <= normal_or_stop && pending;
            wake_req_q <= sleep_or_fail_safe && (|{alt_stat_q, wake_stat_q});
        end
    end

    // write channel: take address and data together, then answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q <= WR_IDLE;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end else begin
            case (wr_state_q)
                WR_IDLE: begin
                    if (wr_fire) begin
                        awready_q <= 1'b0;
                        wready_q <= 1'b0;
                        bvalid_q <= 1'b1;
                        bresp_q <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
                        wr_state_q <= WR_RESP;
                    end else if (awvalid && wvalid && !awready_q) begin
                        awready_q <= 1'b1;
                        wready_q <= 1'b1;
                    end
                end
                WR_RESP: begin
                    if (bready) begin
                        bvalid_q <= 1'b0;
                        wr_state_q <= WR_IDLE;
                    end
                end
                default: begin
                    wr_state_q <= WR_IDLE;
                end
            endcase
        end
    end

    // read channel: one cycle of ready, data registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_q <= RD_IDLE;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RESP_OKAY;
        end else begin
            case (rd_state_q)
                RD_IDLE: begin
                    if (rd_fire) begin
                        arready_q <= 1'b0;
                        rvalid_q <= 1'b1;
                        rdata_q <= rd_word;
                        rresp_q <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
                        rd_state_q <= RD_DATA;
                    end else if (arvalid && !arready_q) begin
                        arready_q <= 1'b1;
                    end
                end
                RD_DATA: begin
                    if (rready) begin
                        rvalid_q <= 1'b0;
                        rd_state_q <= RD_IDLE;
                    end
                end
                default: begin
                    rd_state_q <= RD_IDLE;
                end
            endcase
        end
    end

    // status is readable in every mode
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_known = 1'b1;
        case (araddr)
            ADDR_W'(`OFF_DETECT_CFG): rd_word = 32'(detect_cfg_q);
            ADDR_W'(`OFF_PULL_CFG): rd_word = 32'(pull_cfg_q);
            ADDR_W'(`OFF_WAKE_EN): rd_word = 32'(wake_en_q);
            ADDR_W'(`OFF_WAKE_STAT): rd_word = 32'(wake_stat_q);
            ADDR_W'(`OFF_ALT_STAT): rd_word = 32'(alt_stat_q);
            ADDR_W'(`OFF_LEVEL_STAT): rd_word = 32'(level_stat_q);
            ADDR_W'(`OFF_IRQ_MASK): rd_word = 32'(irq_mask_q);
            default: rd_known = 1'b0;
        endcase
    end

    // outputs straight from flops
    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign wake_pull = wake_pull_q;
    assign irq = irq_q;
    assign wake_req = wake_req_q;
endmodule : wake_input_monitor

// file: wake_chk.sv
// assertions on the wake monitor ports
`timescale 1ns/1ps
module wake_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus responses
    input wire logic bvalid,
    input wire logic bready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic awready,
    // pull controls
    input wire wake_pkg::pull_ctrl_t [2:0] wake_pull,
    // mode and outputs
    input wire wake_pkg::chip_mode_t chip_mode,
    input wire logic irq,
    input wire logic wake_req
);
    import wake_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence b_waiting;
        bvalid && !bready;
    endsequence
    sequence r_waiting;
        rvalid && !rready;
    endsequence
    b_hold_a: assert property (b_waiting |=> bvalid) else $error("bvalid dropped");
    r_hold_a: assert property (r_waiting |=> rvalid) else $error("rvalid dropped");
    aw_pulse_a: assert property (awready |=> !awready)
        else $error("awready held");
    pull_excl_a: assert property ((wake_pull & (wake_pull >> 1) & 6'h15) == 6'h0)
        else $error("pull up and down together");
    irq_mode_a: assert property (irq |-> $past(chip_mode) inside {MODE_NORMAL, MODE_STOP})
        else $error("interrupt outside normal or stop");
    wake_mode_a: assert property (wake_req |-> $past(chip_mode) inside {MODE_SLEEP, MODE_FAIL_SAFE})
        else $error("wake request outside sleep or fail-safe");
    irq_wake_excl_a: assert property (!(irq && wake_req))
        else $error("interrupt and wake request together");
endmodule : wake_chk
bind wake_input_monitor wake_chk chk (.aclk(aclk), .aresetn(aresetn), .bvalid(bvalid),
    .bready(bready), .rvalid(rvalid), .rready(rready), .awready(awready), .wake_pull(wake_pull),
    .chip_mode(chip_mode), .irq(irq), .wake_req(wake_req));

// file: wake_switch.sv
// external switch on one wake pin
`timescale 1ns/1ps
module wake_switch (
    // switch state
    input wire logic closed,
    input wire logic level,
    // pin side
    input wire wake_pkg::pull_ctrl_t pull,
    output logic pin
);
    import wake_pkg::*;
    always_comb pin = closed ? level : pull.up ? 1'h1 : pull.down ? 1'h0 : !level;
endmodule : wake_switch

// file: wake_input_monitor_test.sv
// testbench for the wake input monitor
`timescale 1ns/1ps
`include "wake_defines.svh"
module wake_input_monitor_test;
    import wake_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irq, wake_req, lvl = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d, seed = 32'h6D61;
    logic [1:0] bresp, rresp, r;
    wire [2:0] pin;
    pull_ctrl_t [2:0] pull;
    chip_mode_t mode = MODE_NORMAL;
    logic tmr_a = 0, tmr_b = 0;
    logic [1:0] fo = 0;
    int errors = 0, checks_done = 0, cyc = 0;
    always #20 aclk = ~aclk;
    assign pin[2:1] = 2'h0;
    wake_input_monitor dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .chip_mode(mode), .timer_a_on(tmr_a), .timer_b_on(tmr_b),
        .wake_pin(pin), .fail_out_pins(fo), .wake_pull(pull), .irq(irq), .wake_req(wake_req));
    wake_switch sw (.closed(1'h1), .level(lvl), .pull(pull[0]), .pin(pin[0]));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task wr(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        fork
            begin do @(posedge aclk); while (awready !== 1'h1); awvalid <= 0; end
            begin do @(posedge aclk); while (wready !== 1'h1); wvalid <= 0; end
        join
        do @(posedge aclk); while (bvalid !== 1'h1);
        bready <= 0;
        @(posedge aclk);
    endtask : wr
    task rd(input logic [7:0] a, output logic [31:0] v);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 0;
        do @(posedge aclk); while (rvalid !== 1'h1);
        v = rdata;
        r = rresp;
        rready <= 0;
        @(posedge aclk);
    endtask : rd
    function automatic pull_ctrl_t pull_exp(input logic [1:0] s, input logic l);
        return (s == 2'h3) ? {l, !l} : {s[1], s[0]};
    endfunction : pull_exp
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        repeat (2) @(posedge aclk);
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            lvl <= d[0];
            wr(`OFF_PULL_CFG, i);
            repeat (`FILT_SHORT_CYC + 9) @(posedge aclk);
            chk(pull[0], pull_exp(i[1:0], lvl));
        end
        $display("pull test done");
        wr(`OFF_WAKE_EN, 32'h1);
        wr(`OFF_WAKE_STAT, 32'h1F);
        rd(`OFF_LEVEL_STAT, d);
        chk(d[0], lvl);
        lvl <= ~lvl;
        repeat (5) @(posedge aclk);
        lvl <= ~lvl;
        repeat (`FILT_SHORT_CYC + 9) @(posedge aclk);
        rd(`OFF_WAKE_STAT, d);
        chk(d[0], 1'h0);
        lvl <= ~lvl;
        repeat (`FILT_SHORT_CYC + 9) @(posedge aclk);
        rd(`OFF_WAKE_STAT, d);
        chk(d[0], 1'h1);
        chk(irq, 1'h1);
        mode <= MODE_SLEEP;
        repeat (3) @(posedge aclk);
        chk(wake_req, 1'h1);
        chk(irq, 1'h0);
        mode <= MODE_NORMAL;
        repeat (3) @(posedge aclk);
        wr(`OFF_WAKE_STAT, 32'h1);
        rd(`OFF_WAKE_STAT, d);
        chk(d[0], 1'h0);
        rd(8'h1C, d);
        chk(r, `RESP_SLVERR);
        $display("wake test done");
        wr(`OFF_DETECT_CFG, 32'h2);
        lvl <= !lvl;
        repeat (`FILT_SHORT_CYC + 9) @(posedge aclk);
        rd(`OFF_WAKE_STAT, d);
        chk(d[0], 1'h0);
        rd(`OFF_LEVEL_STAT, d);
        chk(d[0], !lvl);
        tmr_a <= 1'h1;
        repeat (`FILT_SHORT_CYC + 9) @(posedge aclk);
        rd(`OFF_WAKE_STAT, d);
        chk(d[0], 1'h1);
        rd(`OFF_LEVEL_STAT, d);
        chk(d[0], lvl);
        $display("cyclic test done");
        wr(`OFF_WAKE_EN, 32'h9);
        repeat (2) @(posedge aclk);
        fo <= 2'h1;
        repeat (`FILT_SHORT_CYC + 9) @(posedge aclk);
        rd(`OFF_ALT_STAT, d);
        chk(d[1:0], 2'h1);
        $display("fail-out test done");
        final_report();
    end
endmodule : wake_input_monitor_test
